// *** hw/adss_regs.vh ***
`ifndef ADSS_REGS_VH
`define ADSS_REGS_VH

// Register byte offsets
`define ADSS_OFS_CTRL0 8'h00
`define ADSS_OFS_CTRL1 8'h04
`define ADSS_OFS_CTRL2 8'h08
`define ADSS_OFS_TRIG 8'h0C
`define ADSS_OFS_DELAY 8'h10
`define ADSS_OFS_RESH 8'h14
`define ADSS_OFS_RESL 8'h18
`define ADSS_OFS_IRQ 8'h1C
`define ADSS_OFS_PINSEL 8'h20

// Reference source codes
`define ADSS_REF_SUPPLY 2'h0
`define ADSS_REF_EXTPIN 2'h1
`define ADSS_REF_AMP 2'h2

// Internal source codes
`define ADSS_SRC_EXT 3'h0

// Sequence lengths in converter clock periods
`define ADSS_SAMPLE_PERIODS 5'h04
`define ADSS_TOTAL_PERIODS 5'h10

// Last external channel code
`define ADSS_LAST_CHAN 4'h8

// AXI responses
`define ADSS_RESP_OKAY 2'h0
`define ADSS_RESP_SLVERR 2'h2

`endif

// *** hw/adss_top.v ***
// Notes on behaviour
// - reference select: supply, ext pin, amplified
// - gain select code drives amplifier gain
// - amplifier input: ext pin or bandgap
// - amplifier runs only when enabled
// - internal reference disconnects both ext pins
// - analog pins drop other functions, pull-up
// - analog assignment overrides port direction
// - source 000: codes 0..8 pick channels
// - codes above 8 leave input floating
// - internal source field picks internal signals
// - internal source disconnects external channel
// - 4 sample plus 12 convert periods
// - trigger bit picks software or PWM
// - format bit aligns result across registers
// - PWM start delayed when delay enabled
// - busy high during conversion, low after
// - power bit low powers converter down
// - clock divide by 2 to the code
// - end of conversion sets flag, interrupt
// - result is 12 bits, reference full scale
`timescale 1ns/1ps
`include "adss_regs.vh"

module adss_top #(
  parameter NUM_PINS = 9,
  parameter DELAY_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Trigger and converter core
  input wire pwm_trigger,
  input wire [11:0] core_result,
  output reg core_power,
  output reg core_sample,
  output reg core_convert,
  output reg core_clk_tick,
  output reg irq,
  // Analog routing
  output reg [1:0] ref_route,
  output reg ext_ref_pins_connect,
  output reg ref_amp_on,
  output reg [1:0] ref_amp_gain,
  output reg ref_amp_from_bandgap,
  output reg [NUM_PINS-1:0] ext_channel_connect,
  output reg [2:0] internal_source_route,
  // Pin function control
  input wire [NUM_PINS-1:0] pin_pullup_request,
  input wire [NUM_PINS-1:0] pin_dir_output,
  output reg [NUM_PINS-1:0] pin_analog_mode,
  output reg [NUM_PINS-1:0] pin_pullup_on,
  output reg [NUM_PINS-1:0] pin_drive_enable
);

  // ****************************************
  // Software-visible state
  // ****************************************
  reg [3:0] external_channel_select;
  reg start_bit;
  reg converter_power_enable;
  reg [2:0] converter_clock_divide;
  reg [2:0] internal_source_select;
  reg [1:0] ref_source_select;
  reg [1:0] ref_amp_gain_select;
  reg ref_amp_input_select;
  reg ref_amp_enable;
  reg trigger_source_select;
  reg result_format_select;
  reg delayed_start_enable;
  reg [DELAY_W-1:0] start_delay_value;
  reg global_irq_enable;
  reg converter_irq_enable;
  reg converter_irq_flag;
  reg [NUM_PINS-1:0] pin_function_sel;
  reg [7:0] result_high;
  reg [7:0] result_low;
  reg conversion_busy_flag;

  // ****************************************
  // Bus write path
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire flag_clear = do_write & (aw_addr == `ADSS_OFS_IRQ) & ~w_data[2];
  wire conv_done;

  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `ADSS_OFS_CTRL0) | (a == `ADSS_OFS_CTRL1) |
        (a == `ADSS_OFS_CTRL2) | (a == `ADSS_OFS_TRIG) |
        (a == `ADSS_OFS_DELAY) | (a == `ADSS_OFS_RESH) |
        (a == `ADSS_OFS_RESL) | (a == `ADSS_OFS_IRQ) |
        (a == `ADSS_OFS_PINSEL);
    end
  endfunction

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADSS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr) ? `ADSS_RESP_OKAY : `ADSS_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Registers other than the interrupt flag are written only when the low byte lane strobe is set; pin select bit 8 comes from the next lane
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      external_channel_select <= 4'h0;
      start_bit <= 1'b0;
      converter_power_enable <= 1'b0;
      converter_clock_divide <= 3'h0;
      internal_source_select <= 3'h0;
      ref_source_select <= 2'h0;
      ref_amp_gain_select <= 2'h0;
      ref_amp_input_select <= 1'b0;
      ref_amp_enable <= 1'b0;
      trigger_source_select <= 1'b0;
      result_format_select <= 1'b0;
      delayed_start_enable <= 1'b0;
      start_delay_value <= {DELAY_W{1'b0}};
      global_irq_enable <= 1'b0;
      converter_irq_enable <= 1'b0;
      pin_function_sel <= {NUM_PINS{1'b0}};
    end
    else if (do_write & s_axi_wstrb[0])
    begin
      case (aw_addr)
        `ADSS_OFS_CTRL0:
        begin
          external_channel_select <= w_data[3:0];
          start_bit <= w_data[4];
          converter_power_enable <= w_data[5];
        end
        `ADSS_OFS_CTRL1:
        begin
          converter_clock_divide <= w_data[2:0];
          internal_source_select <= w_data[6:4];
        end
        `ADSS_OFS_CTRL2:
        begin
          ref_source_select <= w_data[1:0];
          ref_amp_gain_select <= w_data[3:2];
          ref_amp_input_select <= w_data[4];
          ref_amp_enable <= w_data[5];
        end
        `ADSS_OFS_TRIG:
        begin
          trigger_source_select <= w_data[0];
          result_format_select <= w_data[1];
          delayed_start_enable <= w_data[2];
        end
        `ADSS_OFS_DELAY: start_delay_value <= w_data[DELAY_W-1:0];
        `ADSS_OFS_IRQ:
        begin
          global_irq_enable <= w_data[0];
          converter_irq_enable <= w_data[1];
        end
        `ADSS_OFS_PINSEL: pin_function_sel <= w_data[NUM_PINS-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Bus read path
  // ****************************************
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      `ADSS_OFS_CTRL0: next_rdata[6:0] = {conversion_busy_flag, converter_power_enable,
        start_bit, external_channel_select};
      `ADSS_OFS_CTRL1: next_rdata[6:0] = {internal_source_select, 1'b0, converter_clock_divide};
      `ADSS_OFS_CTRL2: next_rdata[5:0] = {ref_amp_enable, ref_amp_input_select,
        ref_amp_gain_select, ref_source_select};
      `ADSS_OFS_TRIG: next_rdata[2:0] = {delayed_start_enable, result_format_select,
        trigger_source_select};
      `ADSS_OFS_DELAY: next_rdata[DELAY_W-1:0] = start_delay_value;
      `ADSS_OFS_RESH: next_rdata[7:0] = result_high;
      `ADSS_OFS_RESL: next_rdata[7:0] = result_low;
      `ADSS_OFS_IRQ: next_rdata[2:0] = {converter_irq_flag, converter_irq_enable,
        global_irq_enable};
      `ADSS_OFS_PINSEL: next_rdata[NUM_PINS-1:0] = pin_function_sel;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ADSS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= addr_known({s_axi_araddr[7:2], 2'b00}) ?
          `ADSS_RESP_OKAY : `ADSS_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Converter clock and sequencer
  // ****************************************
  reg [6:0] div_count;
  reg start_prev;
  reg [4:0] period_count;
  reg [DELAY_W-1:0] delay_count;
  reg delay_pending;
  wire [6:0] div_last = (7'h01 << converter_clock_divide) - 7'h01;
  wire adc_tick = (div_count == div_last);
  wire sw_rise = ~trigger_source_select & start_bit & ~start_prev;
  wire sw_fall = ~trigger_source_select & ~start_bit & start_prev;
  wire pwm_go = trigger_source_select & pwm_trigger;
  wire delay_go = delay_pending & adc_tick & (delay_count == {DELAY_W{1'b0}});
  wire begin_conv = converter_power_enable &
    (sw_fall | (pwm_go & ~delayed_start_enable) | delay_go);
  assign conv_done = conversion_busy_flag & adc_tick &
    (period_count == `ADSS_TOTAL_PERIODS - 5'h01);

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      div_count <= 7'h00;
    else if (adc_tick | begin_conv)
      div_count <= 7'h00;
    else
      div_count <= div_count + 7'h01;
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      start_prev <= 1'b0;
      period_count <= 5'h00;
      conversion_busy_flag <= 1'b0;
      delay_pending <= 1'b0;
      delay_count <= {DELAY_W{1'b0}};
      result_high <= 8'h00;
      result_low <= 8'h00;
    end
    else
    begin
      start_prev <= start_bit;
      if (~converter_power_enable | sw_rise)
      begin
        conversion_busy_flag <= 1'b0;
        delay_pending <= 1'b0;
        period_count <= 5'h00;
      end
      else if (begin_conv)
      begin
        conversion_busy_flag <= 1'b1;
        delay_pending <= 1'b0;
        period_count <= 5'h00;
      end
      else
      begin
        if (pwm_go & delayed_start_enable)
        begin
          delay_pending <= 1'b1;
          delay_count <= start_delay_value;
        end
        else if (delay_pending & adc_tick)
          delay_count <= delay_count - {{(DELAY_W-1){1'b0}}, 1'b1};
        if (conv_done)
        begin
          conversion_busy_flag <= 1'b0;
          if (result_format_select)
          begin
            result_high <= {4'h0, core_result[11:8]};
            result_low <= core_result[7:0];
          end
          else
          begin
            result_high <= core_result[11:4];
            result_low <= {core_result[3:0], 4'h0};
          end
        end
        else if (conversion_busy_flag & adc_tick)
          period_count <= period_count + 5'h01;
      end
    end
  end

  // Set beats a clear arriving in the same cycle
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      converter_irq_flag <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (conv_done & converter_power_enable)
        converter_irq_flag <= 1'b1;
      else if (flag_clear)
        converter_irq_flag <= 1'b0;
      irq <= global_irq_enable & converter_irq_enable & converter_irq_flag;
    end
  end

  // ****************************************
  // Core and analog routing outputs
  // ****************************************
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      core_power <= 1'b0;
      core_sample <= 1'b0;
      core_convert <= 1'b0;
      core_clk_tick <= 1'b0;
      ref_route <= `ADSS_REF_SUPPLY;
      ext_ref_pins_connect <= 1'b0;
      ref_amp_on <= 1'b0;
      ref_amp_gain <= 2'h0;
      ref_amp_from_bandgap <= 1'b0;
      ext_channel_connect <= {NUM_PINS{1'b0}};
      internal_source_route <= `ADSS_SRC_EXT;
      pin_analog_mode <= {NUM_PINS{1'b0}};
      pin_pullup_on <= {NUM_PINS{1'b0}};
      pin_drive_enable <= {NUM_PINS{1'b0}};
    end
    else
    begin
      core_power <= converter_power_enable;
      core_sample <= conversion_busy_flag & (period_count < `ADSS_SAMPLE_PERIODS);
      core_convert <= conversion_busy_flag & (period_count >= `ADSS_SAMPLE_PERIODS);
      core_clk_tick <= adc_tick & converter_power_enable;
      // Codes 10 and 11 both mean the amplified reference
      ref_route <= ref_source_select[1] ? `ADSS_REF_AMP : ref_source_select;
      ext_ref_pins_connect <= ~ref_source_select[1];
      ref_amp_on <= ref_amp_enable;
      ref_amp_gain <= ref_amp_gain_select;
      ref_amp_from_bandgap <= ref_amp_input_select;
      internal_source_route <= internal_source_select;
      // Internal source wins so two signals never short together
      if (internal_source_select == `ADSS_SRC_EXT &&
          external_channel_select <= `ADSS_LAST_CHAN)
        ext_channel_connect <= {{(NUM_PINS-1){1'b0}}, 1'b1} << external_channel_select;
      else
        ext_channel_connect <= {NUM_PINS{1'b0}};
      pin_analog_mode <= pin_function_sel;
      pin_pullup_on <= pin_pullup_request & ~pin_function_sel;
      pin_drive_enable <= pin_dir_output & ~pin_function_sel;
    end
  end

endmodule

// *** tb/adss_analog_model.sv ***
`timescale 1ns/1ps
// ******
// Analog side: level coded from the routed source
// ******
module adss_analog_model #(
  parameter NUM_PINS = 9
) (
  input wire sys_clk,
  input wire [NUM_PINS-1:0] ext_channel_connect,
  input wire [2:0] internal_source_route,
  input wire core_sample,
  input wire core_convert,
  output reg [11:0] core_result
);
  reg [11:0] held = 12'hA5A;
  reg [3:0] ch;
  integer i;
  always @*
  begin
    ch = 4'hF;
    for (i = 0; i < NUM_PINS; i = i + 1)
      if (ext_channel_connect[i])
        ch = i[3:0];
  end
  always @(posedge sys_clk)
    if (core_sample)
      held <= {internal_source_route, ch, 5'h15};
  // Outside conversion the output is not trustworthy, so show the inverse
  always @*
    core_result = core_convert ? held : ~held;
endmodule

// *** tb/adss_monitor.sv ***
`timescale 1ns/1ps
// ******
// Port checks
// ******
module adss_monitor #(
  parameter NUM_PINS = 9
) (
  // Clock, reset, bus
  input wire sys_clk,
  input wire reset,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Converter and routing
  input wire core_power,
  input wire core_sample,
  input wire core_convert,
  input wire [1:0] ref_route,
  input wire ext_ref_pins_connect,
  input wire [NUM_PINS-1:0] ext_channel_connect,
  input wire [2:0] internal_source_route,
  input wire [NUM_PINS-1:0] pin_analog_mode,
  input wire [NUM_PINS-1:0] pin_pullup_on,
  input wire [NUM_PINS-1:0] pin_drive_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence powered_off_s;
    !core_power [*2];
  endsequence
  sequence conv_start_s;
    !core_convert ##1 core_convert;
  endsequence
  ref_code_a: assert property (ref_route != 2'h3)
    else $error("reference route code 3 seen");
  ref_pins_off_a: assert property (ref_route == 2'h2 |-> !ext_ref_pins_connect)
    else $error("external reference pins left connected");
  pullup_cut_a: assert property ((pin_pullup_on & pin_analog_mode) == '0)
    else $error("pull-up on an analog pin");
  drive_cut_a: assert property ((pin_drive_enable & pin_analog_mode) == '0)
    else $error("output driver on an analog pin");
  chan_onehot_a: assert property ($onehot0(ext_channel_connect))
    else $error("two channels connected");
  int_src_cut_a: assert property (internal_source_route != 3'h0 |-> ext_channel_connect == '0)
    else $error("external channel with internal source");
  phase_excl_a: assert property (!(core_sample && core_convert))
    else $error("sample and convert together");
  sample_first_a: assert property (conv_start_s |-> $past(core_sample))
    else $error("convert without sampling first");
  power_off_a: assert property (powered_off_s |-> !core_sample && !core_convert)
    else $error("activity while powered down");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule

bind adss_top adss_monitor #(.NUM_PINS(NUM_PINS)) mon_u (.*);

// *** tb/adss_tb_top.sv ***
`timescale 1ns/1ps
module adss_tb_top;
  reg sys_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready, pwm_trigger;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd, v;
  reg [3:0] s_axi_wstrb;
  reg [1:0] rs;
  reg [8:0] pin_pullup_request, pin_dir_output;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, ref_route, ref_amp_gain;
  wire [31:0] s_axi_rdata;
  wire [11:0] core_result;
  wire core_power, core_sample, core_convert, core_clk_tick, irq;
  wire ext_ref_pins_connect, ref_amp_on, ref_amp_from_bandgap;
  wire [8:0] ext_channel_connect, pin_analog_mode, pin_pullup_on, pin_drive_enable;
  wire [2:0] internal_source_route;
  integer miscompares, n_tests, seed, ns, nc, nt, t, k, s, e;

  adss_top #(.NUM_PINS(9), .DELAY_W(8)) dut_u (.*);
  adss_analog_model #(.NUM_PINS(9)) model_u (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    ns <= ns + core_sample;
    nc <= nc + core_convert;
    nt <= nt + core_clk_tick;
  end

  // ******
  // Checking and bus tasks
  // ******
  task report_and_stop;
  begin
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task give_up(input integer n);
  begin
    if (n >= 300)
    begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 300 && !(s_axi_bvalid && s_axi_bready); t = t + 1)
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    give_up(t);
  end
  endtask
  task rd_reg(input [7:0] a);
  begin
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 300 && !(s_axi_rvalid && s_axi_rready); t = t + 1)
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    give_up(t);
  end
  endtask
  // Reference of the analog model: channel field is F when nothing external is routed
  function [11:0] exp_res(input [2:0] src, input [3:0] ch);
    exp_res = {src, (src != 3'h0 || ch > 4'h8) ? 4'hF : ch, 5'h15};
  endfunction
  task convert(input [2:0] div, input pwm, input fmt, input [2:0] src, input [3:0] ch);
    integer s0, c0;
    reg [11:0] r;
  begin
    r = exp_res(src, ch);
    wr(8'h04, {25'h0, src, 1'b0, div});
    wr(8'h0C, {29'h0, pwm, fmt, pwm});
    wr(8'h00, 32'h20 | ch);
    s0 = ns;
    c0 = nc;
    if (pwm)
    begin
      @(posedge sys_clk);
      pwm_trigger <= 1'b1;
      @(posedge sys_clk);
      pwm_trigger <= 1'b0;
    end
    else
    begin
      wr(8'h00, 32'h30 | ch);
      wr(8'h00, 32'h20 | ch);
    end
    for (k = 0; k < 300 && !core_sample; k = k + 1)
      @(posedge sys_clk);
    give_up(k);
    rd = 32'h40;
    for (k = 0; k < 300 && rd[6]; k = k + 1)
      rd_reg(8'h00);
    give_up(k);
    chk(ns - s0, 4 << div);
    chk(nc - c0, 12 << div);
    rd_reg(8'h14);
    chk(rd, fmt ? r[11:8] : r[11:4]);
    rd_reg(8'h18);
    chk(rd, fmt ? r[7:0] : {r[3:0], 4'h0});
    rd_reg(8'h1C);
    chk(rd[2], 1'b1);
    chk(irq, 1'b1);
    wr(8'h1C, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
  end
  endtask

  // ******
  // Main sequence
  // ******
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    pwm_trigger = 1'b0;
    pin_pullup_request = 9'h000;
    pin_dir_output = 9'h000;
    seed = 32'hef33b2e1;
    {miscompares, n_tests, ns, nc, nt} = 160'h0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd_reg(8'h00);
    chk(rd, 32'h0);
    rd_reg(8'h24);
    chk(rs, 2'h2);
    chk(rd, 32'h0);
    wr(8'h28, 32'hFF);
    chk(rs, 2'h2);
    for (k = 0; k < 64; k = k + 1)
    begin
      wr(8'h08, k);
      repeat (2) @(posedge sys_clk);
      chk(ref_route, k[1] ? 2'h2 : k[1:0]);
      chk(ext_ref_pins_connect, !k[1]);
      chk(ref_amp_gain, k[3:2]);
      chk(ref_amp_from_bandgap, k[4]);
      chk(ref_amp_on, k[5]);
    end
    for (k = 0; k < 24; k = k + 1)
    begin
      s = (k > 16) ? k - 16 : 0;
      e = (k > 16 || k[3:0] > 8) ? 0 : 1 << k[3:0];
      wr(8'h04, s << 4);
      wr(8'h00, 32'h20 | k[3:0]);
      repeat (2) @(posedge sys_clk);
      chk(internal_source_route, s);
      chk(ext_channel_connect, e);
    end
    for (k = 0; k < 8; k = k + 1)
    begin
      v = $random(seed);
      wr(8'h20, v[8:0]);
      pin_pullup_request <= v[17:9];
      pin_dir_output <= v[26:18];
      repeat (3) @(posedge sys_clk);
      chk(pin_analog_mode, v[8:0]);
      chk(pin_pullup_on, v[17:9] & ~v[8:0]);
      chk(pin_drive_enable, v[26:18] & ~v[8:0]);
    end
    wr(8'h1C, 32'h3);
    wr(8'h10, 32'h3);
    chk(rs, 2'h0);
    rd_reg(8'h10);
    chk(rd, 32'h3);
    convert(3'h1, 1'b0, 1'b0, 3'h0, 4'h5);
    convert(3'h2, 1'b1, 1'b1, 3'h3, 4'h2);
    convert(3'h0, 1'b0, 1'b1, 3'h0, 4'h8);
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h00);
    s = ns;
    wr(8'h00, 32'h10);
    e = nt;
    wr(8'h00, 32'h00);
    repeat (40) @(posedge sys_clk);
    chk(core_power, 1'b0);
    chk(nt - e, 0);
    chk(ns - s, 0);
    rd_reg(8'h00);
    chk(rd[6], 1'b0);
    report_and_stop;
  end
endmodule
